// ### tpd_defs.vh
// constants shared by the debug probe port files
// assumes a 40 MHz reference clock and a byte-addressed Avalon-MM slave
`ifndef TPD_DEFS_VH
`define TPD_DEFS_VH

// ********************************************************
// register offsets (byte addresses)
// ********************************************************
`define TPD_OFF_CTRL    4'h0
`define TPD_OFF_SCEN    4'h4
`define TPD_OFF_DIV     4'h8
`define TPD_OFF_STAT    4'hC

// ********************************************************
// field positions and reset values
// ********************************************************
`define TPD_CTRL_OVR    0
`define TPD_STAT_VALID  8
`define TPD_STAT_DRV_LO 16
`define TPD_CTRL_RST    1'h0
`define TPD_SCEN_RST    3'h0
`define TPD_DIV_RST     8'h01

// ********************************************************
// scenario codes and output patterns
// ********************************************************
`define TPD_SCEN_QUIET  3'h0
`define TPD_SCEN_CLKDBG 3'h2
`define TPD_CLK_MASK    8'h87
`define TPD_LEVEL_PAT   8'h68

// ********************************************************
// timing
// ********************************************************
`define TPD_REF_KHZ     40000
`define TPD_F0_KHZ      60000
`define TPD_F1_KHZ      30000
`define TPD_F7_KHZ      7500
`define TPD_F2MIN_KHZ   700
`define TPD_F2MAX_KHZ   22500
`define TPD_SETTLE      3'h4

`endif

// ### tpd_pin_sync.v
// three-stage synchroniser for the probe pin inputs
// assumes asynchronous pin levels and one reference clock
module tpd_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] pinStable
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;

    // ********************************************************
    // shift chain; a value counts once stages two and three agree
    // ********************************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1    <= {WIDTH{1'b0}};
            stage2    <= {WIDTH{1'b0}};
            stage3    <= {WIDTH{1'b0}};
            pinStable <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                pinStable <= stage3;
            end
        end
    end

endmodule

// ### tpd_clock_div.v
// toggle divider producing one debug clock from the reference clock
// assumes halfPeriod of at least one; zero is treated as one
module tpd_clock_div (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       enable,
    input  wire [7:0] halfPeriod,
    output reg        clkOut
);

    reg [7:0] count;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count  <= 8'h00;
            clkOut <= 1'b0;
        end else if (!enable) begin
            count  <= 8'h00;
            clkOut <= 1'b0;
        end else if (count + 8'h01 >= halfPeriod) begin
            count  <= 8'h00;
            clkOut <= ~clkOut;
        end else begin
            count <= count + 8'h01;
        end
    end

endmodule

// ### tpd_debug_port.v
// eight-pin calibration and debug probe port with an Avalon-MM register slave
// assumes rst is the system reset, straps hold steady around its release,
// and an external pin model resolves each pin from its active-low enable
//
// Function
// - all eight probe pins stay undriven inputs during reset and become outputs after release only while the clock debug code is active.
// - the pin levels are sampled after reset release and held as the configuration until reset.
// - capture happens once per reset release; later pin changes have no effect.
// - the all-zero pulldown default leaves all eight pins undriven.
// - the clock debug code drives clocks on pins 0, 1, 2 and 7, pins 3, 5, 6 high, pin 4 low.
// - software may replace the strap selection at any time after reset.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`include "tpd_defs.vh"

module tpd_debug_port #(
    parameter PINS = 8
) (
    input  wire            ref_clk,
    input  wire            rst,
    input  wire [3:0]      avs_address,
    input  wire            avs_read,
    input  wire            avs_write,
    input  wire [3:0]      avs_byteenable,
    input  wire [31:0]     avs_writedata,
    output reg  [31:0]     avs_readdata,
    output wire            avs_waitrequest,
    input  wire [PINS-1:0] debugProbePinIn,
    output reg  [PINS-1:0] debugProbePinOut,
    output reg  [PINS-1:0] debugProbePinOeN,
    output reg  [PINS-1:0] strapCapture,
    output reg             strapValid
);

    // ********************************************************
    // debug clock half periods in reference cycles
    // ********************************************************
    // 60 and 30 MHz are beyond a toggle of the 40 MHz reference; both clamp
    // to a one-cycle half period (20 MHz), and 7.5 MHz rounds to 10 MHz
    localparam integer HP0_RAW   = `TPD_REF_KHZ / (2 * `TPD_F0_KHZ);
    localparam integer HP1_RAW   = `TPD_REF_KHZ / (2 * `TPD_F1_KHZ);
    localparam integer HP7_RAW   = `TPD_REF_KHZ / (2 * `TPD_F7_KHZ);
    localparam integer HP2_MAXR  = `TPD_REF_KHZ / (2 * `TPD_F2MIN_KHZ);
    localparam integer HP2_MINR  = (`TPD_REF_KHZ + 2 * `TPD_F2MAX_KHZ - 1)
                                   / (2 * `TPD_F2MAX_KHZ);
    localparam [7:0]   HP0       = (HP0_RAW < 1) ? 8'h01 : HP0_RAW[7:0];
    localparam [7:0]   HP1       = (HP1_RAW < 1) ? 8'h01 : HP1_RAW[7:0];
    localparam [7:0]   HP7       = (HP7_RAW < 1) ? 8'h01 : HP7_RAW[7:0];
    localparam [7:0]   HP2_MAX   = (HP2_MAXR < 1) ? 8'h01 : HP2_MAXR[7:0];
    localparam [7:0]   HP2_MIN   = (HP2_MINR < 1) ? 8'h01 : HP2_MINR[7:0];

    localparam integer    STAT_SCEN_LO = 24;
    localparam [PINS-1:0] LEVEL_PAT    = `TPD_LEVEL_PAT;

    // ********************************************************
    // capture states
    // ********************************************************
    localparam [1:0] ST_SETTLE  = 2'h0;
    localparam [1:0] ST_CAPTURE = 2'h1;
    localparam [1:0] ST_RUN     = 2'h2;

    // ********************************************************
    // state and datapath signals
    // ********************************************************
    reg  [1:0]      state;
    reg  [1:0]      next_state;
    reg  [2:0]      settleCount;
    wire [PINS-1:0] pinStable;

    reg             swOverride;
    reg  [2:0]      swScenario;
    reg  [7:0]      pin2Half;
    reg             busAck;

    reg  [2:0]      activeScenario;
    reg             clockDebug;
    wire [3:0]      divClk;
    reg  [7:0]      divHalf [0:3];
    reg  [PINS-1:0] next_pinOut;
    reg  [PINS-1:0] next_oeN;
    reg  [31:0]     next_readdata;
    wire            busReq;
    wire            busTake;
    wire            wrLow;
    reg  [7:0]      divClamped;
    wire [PINS-1:0] pinSource;

    // ********************************************************
    // strap sampling
    // ********************************************************
    // straps pass the three-flop chain before they count
    tpd_pin_sync #(
        .WIDTH     (PINS)
    ) u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pinIn     (debugProbePinIn),
        .pinStable (pinStable)
    );

    // the chain needs three edges to fill and one more to agree, so capture
    // waits out the settle count and then takes the strap present at release
    // pins stay undriven until the strap is taken, so the chain sees only straps
    always @* begin
        next_state = state;
        case (state)
            ST_SETTLE: begin
                if (settleCount >= `TPD_SETTLE) begin
                    next_state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                next_state = ST_RUN;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_SETTLE;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state        <= ST_SETTLE;
            settleCount  <= 3'h0;
            strapCapture <= {PINS{1'b0}};
            strapValid   <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_SETTLE) begin
                settleCount <= settleCount + 3'h1;
            end
            // strap is taken once, on the single pass through capture
            if (state == ST_CAPTURE) begin
                strapCapture <= pinStable;
                strapValid   <= 1'b1;
            end
        end
    end

    // ********************************************************
    // register slave
    // ********************************************************
    // one wait state on every access: the ack flop rises in the first request
    // cycle, read data is loaded on that same edge, and a write lands on the
    // edge that ends the second cycle, and only with byte lane 0 enabled
    assign busReq          = avs_read | avs_write;
    assign busTake         = busReq & busAck;
    assign avs_waitrequest = busReq & ~busAck;
    assign wrLow           = avs_write & busTake & avs_byteenable[0];

    // pin 2 half period is clamped on write to keep it inside its allowed band
    always @* begin
        divClamped = avs_writedata[7:0];
        if (divClamped < HP2_MIN) begin
            divClamped = HP2_MIN;
        end else if (divClamped > HP2_MAX) begin
            divClamped = HP2_MAX;
        end
    end

    always @* begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            `TPD_OFF_CTRL: begin
                next_readdata[`TPD_CTRL_OVR] = swOverride;
            end
            `TPD_OFF_SCEN: begin
                next_readdata[2:0] = swScenario;
            end
            `TPD_OFF_DIV: begin
                next_readdata[7:0] = pin2Half;
            end
            `TPD_OFF_STAT: begin
                // live status: strap, capture flag, driven pins, active scenario
                next_readdata[PINS-1:0]                     = strapCapture;
                next_readdata[`TPD_STAT_VALID]              = strapValid;
                next_readdata[`TPD_STAT_DRV_LO+PINS-1:16]   = ~debugProbePinOeN;
                next_readdata[STAT_SCEN_LO+2:STAT_SCEN_LO]  = activeScenario;
            end
            default: begin
                next_readdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busAck       <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            swOverride   <= `TPD_CTRL_RST;
            swScenario   <= `TPD_SCEN_RST;
            pin2Half     <= `TPD_DIV_RST;
        end else begin
            busAck <= busReq & ~busAck;
            if (avs_read & ~busAck) begin
                avs_readdata <= next_readdata;
            end
            if (wrLow) begin
                case (avs_address)
                    `TPD_OFF_CTRL: begin
                        swOverride <= avs_writedata[`TPD_CTRL_OVR];
                    end
                    `TPD_OFF_SCEN: begin
                        swScenario <= avs_writedata[2:0];
                    end
                    `TPD_OFF_DIV: begin
                        pin2Half <= divClamped;
                    end
                    default: begin
                        swOverride <= swOverride;
                    end
                endcase
            end
        end
    end

    // ********************************************************
    // scenario selection
    // ********************************************************
    always @* begin
        // the strap only gives the default; a software override replaces it
        if (swOverride) begin
            activeScenario = swScenario;
        end else begin
            activeScenario = strapCapture[2:0];
        end
        clockDebug = strapValid && (state == ST_RUN)
                     && (activeScenario == `TPD_SCEN_CLKDBG);
    end

    // ********************************************************
    // debug clocks on pins 0, 1, 2 and 7
    // ********************************************************
    always @* begin
        divHalf[0] = HP0;
        divHalf[1] = HP1;
        divHalf[2] = pin2Half;
        divHalf[3] = HP7;
    end

    // dividers stop and park low outside clock debug, so a re-enable starts clean
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_div
            tpd_clock_div u_div (
                .ref_clk    (ref_clk),
                .rst        (rst),
                .enable     (clockDebug),
                .halfPeriod (divHalf[gi]),
                .clkOut     (divClk[gi])
            );
        end
    endgenerate

    // ********************************************************
    // per-pin source in clock debug
    // ********************************************************
    genvar pi;
    generate
        for (pi = 0; pi < PINS; pi = pi + 1) begin : g_pin
            if (pi == 0) begin : g_fast0
                assign pinSource[pi] = divClk[0];
            end else if (pi == 1) begin : g_fast1
                assign pinSource[pi] = divClk[1];
            end else if (pi == 2) begin : g_var2
                assign pinSource[pi] = divClk[2];
            end else if (pi == 7) begin : g_slow7
                assign pinSource[pi] = divClk[3];
            end else begin : g_level
                assign pinSource[pi] = LEVEL_PAT[pi];
            end
        end
    endgenerate

    // ********************************************************
    // pin drive
    // ********************************************************
    // pins leave high impedance only for the clock debug code
    always @* begin
        next_pinOut = {PINS{1'b0}};
        next_oeN    = {PINS{1'b1}};
        if (clockDebug) begin
            next_oeN    = {PINS{1'b0}};
            next_pinOut = pinSource;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            debugProbePinOut <= {PINS{1'b0}};
            debugProbePinOeN <= {PINS{1'b1}};
        end else begin
            debugProbePinOut <= next_pinOut;
            debugProbePinOeN <= next_oeN;
        end
    end

endmodule

// ### tpd_debug_port_monitor.sv
// checker for the debug probe port
// assumes it is bound to tpd_debug_port
module tpd_debug_port_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [7:0] debugProbePinOut,
    input wire logic [7:0] debugProbePinOeN,
    input wire logic [7:0] strapCapture,
    input wire logic       strapValid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_undriven_early: assert property (!strapValid |-> debugProbePinOeN == 8'hFF)
        else $error("pins driven before capture");
    a_valid_held: assert property (strapValid |=> strapValid)
        else $error("capture flag dropped");
    a_capture_fixed: assert property (strapValid && $past(strapValid) |-> $stable(strapCapture))
        else $error("capture changed after release");
    a_uniform_oe: assert property (debugProbePinOeN == 8'hFF || debugProbePinOeN == 8'h00)
        else $error("partial pin drive");
    a_drive_levels: assert property (debugProbePinOeN == 8'h00 |-> (debugProbePinOut & 8'h78) == 8'h68)
        else $error("static debug levels wrong");
    a_fast_toggle: assert property (debugProbePinOeN == 8'h00 && $past(debugProbePinOeN) == 8'h00
        |-> (debugProbePinOut[1:0] ^ $past(debugProbePinOut[1:0])) == 2'b11)
        else $error("pins 0 and 1 not toggling");
    a_slow_toggle: assert property ((debugProbePinOeN == 8'h00) [*4]
        |-> debugProbePinOut[7] != $past(debugProbePinOut[7], 2))
        else $error("pin 7 rate wrong");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    c_clkdbg: cover property (debugProbePinOeN == 8'h00);
    c_write: cover property (avs_write && !avs_waitrequest);
    c_capture: cover property ($rose(strapValid));
endmodule

// ### tpd_strap_board.sv
// board straps and pulldowns that resolve each probe pin
// assumes active-low enables from the port
module tpd_strap_board (
    input wire logic [7:0]  strap,
    input wire logic [7:0]  pinOut,
    input wire logic [7:0]  pinOeN,
    output wire logic [7:0] pinLevel
);
    // an undriven pin settles to its strap, else the pulldown
    assign pinLevel = (pinOut & ~pinOeN) | (strap & pinOeN);
endmodule

// ### tpd_debug_port_test.sv
// self-checking bench for the debug probe port
// assumes the strap board model and the monitor alongside
`include "tpd_defs.vh"
module tpd_debug_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  strap = 8'h00;
    logic [7:0]  pinLevel;
    logic [7:0]  pinOut;
    logic [7:0]  pinOeN;
    logic [7:0]  strapCapture;
    logic        strapValid;
    int          num_errors = 0;
    int          compares = 0;
    always #12.5 ref_clk = ~ref_clk;
    tpd_debug_port dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .debugProbePinIn(pinLevel),
        .debugProbePinOut(pinOut), .debugProbePinOeN(pinOeN),
        .strapCapture(strapCapture), .strapValid(strapValid));
    tpd_strap_board board (.strap(strap), .pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel));
    task automatic print_verdict;
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(32'(n < 20), 32'h1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, e);
    endtask
    task automatic apply(input logic [7:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        strap <= s;
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk({16'h0, pinOeN, pinLevel}, {16'h0, 8'hFF, s});
        rst <= 1'b0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (strapValid !== 1'b1 && n < 20);
        chk({23'h0, strapValid, strapCapture}, {24'h1, s});
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_quiet;
        apply(8'h00);
        chk(32'(pinOeN), 32'hFF);
        rd(`TPD_OFF_STAT, 32'h00000100);
        rd(4'h1, 32'h0);
        rd(`TPD_OFF_DIV, 32'h1);
    endtask
    task automatic t_clock;
        logic [7:0]  prev;
        logic [7:0]  x;
        logic [31:0] cnt;
        apply(8'h02);
        strap <= 8'h05;
        wr(`TPD_OFF_DIV, 32'h3, 4'hF);
        repeat (4) @(posedge ref_clk);
        cnt = 32'h0;
        @(negedge ref_clk);
        prev = pinLevel;
        repeat (24) begin
            @(negedge ref_clk);
            x = pinLevel ^ prev;
            cnt = cnt + {7'h0, x[0], 7'h0, x[1], 7'h0, x[2], 7'h0, x[7]};
            prev = pinLevel;
        end
        chk(cnt, {8'h18, 8'h18, 8'h08, 8'h0C});
        chk(32'(pinLevel & 8'h78), 32'h68);
        rd(`TPD_OFF_STAT, 32'h02FF0102);
    endtask
    task automatic t_soft;
        apply(8'h05);
        chk(32'(pinOeN), 32'hFF);
        wr(`TPD_OFF_SCEN, 32'h2, 4'hF);
        wr(`TPD_OFF_CTRL, 32'h1, 4'hF);
        wr(`TPD_OFF_SCEN, 32'h3, 4'h0);
        repeat (3) @(posedge ref_clk);
        chk(32'(pinOeN), 32'h0);
        wr(`TPD_OFF_STAT, 32'h0, 4'hF);
        rd(`TPD_OFF_STAT, 32'h02FF0105);
        wr(`TPD_OFF_SCEN, 32'h3, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk(32'(pinOeN), 32'hFF);
        wr(`TPD_OFF_DIV, 32'h0, 4'hF);
        rd(`TPD_OFF_DIV, 32'h1);
        wr(`TPD_OFF_DIV, 32'h40, 4'hF);
        rd(`TPD_OFF_DIV, 32'h1C);
    endtask
    initial begin
        t_quiet();
        t_clock();
        t_soft();
        print_verdict();
    end
    initial begin
        repeat (4000) @(posedge ref_clk);
        chk(32'h0, 32'h1);
        print_verdict();
    end
endmodule
bind tpd_debug_port tpd_debug_port_monitor mon (.ref_clk(ref_clk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .debugProbePinOut(debugProbePinOut), .debugProbePinOeN(debugProbePinOeN),
    .strapCapture(strapCapture), .strapValid(strapValid));
